/* lcs_link_ctl_stat.v */
// lcs_link_ctl_stat.v: link control and status register of the express
// capability, reached over an axi4-lite slave port.
// assumes clk and arst_n from the bridge core; the loader strobe and the
// slot clock value come from the eeprom loader on the same clock.
//
// Register access over AXI4-Lite was left to the implementer.
`include "lcs_defines.vh"
`default_nettype none

// Notes on behaviour
// - data link active bit always reads zero
// - slot clock flag read-only, eeprom loadable
// - width field reads single-lane code 000001
// - speed field reads 2.5 Gbps code
// - extended sync bit lengthens synchronization
// - writable common clock bit, resets zero
// - exit latency same for either common clock bit
// - retrain bit reads zero, not writable
// - link off bit reads zero, not writable
// - completion boundary bit: 0=64B, 1=128B
// - power state control: 00 off, 01 L0s
// - reserved bit 2 reads zero
module lcs_link_ctl_stat #(
  parameter ADDR_W = `LCS_ADDR_W,
  parameter [5:0] WIDTH_CODE = `LCS_WIDTH_X1,
  parameter [3:0] SPEED_CODE = `LCS_SPEED_2G5
) (
  input wire clk,
  input wire arst_n,
  // axi4-lite slave
  input wire [ADDR_W-1:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [ADDR_W-1:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  // eeprom loader
  input wire slot_clock_load,
  input wire slot_clock_value,
  // controls towards the link logic
  output wire ext_sync_en,
  output wire [7:0] sync_length,
  output wire common_clock_select,
  output wire completion_boundary_bit,
  output wire [1:0] power_state_control_field,
  output wire l0s_entry_en,
  output wire [2:0] l0s_exit_latency,
  output wire [2:0] l1_exit_latency
);

  // ---------------------------------------------------------------------
  // control bits
  // ---------------------------------------------------------------------
  reg ext_sync_ff;
  reg common_clk_ff;
  reg compl_bound_ff;
  reg [1:0] psc_ff;
  reg slot_clock_ff;
  reg slot_loaded_ff;
  reg [7:0] sync_len_ff;
  reg nxt_ext_sync;
  reg nxt_common_clk;
  reg nxt_compl_bound;
  reg [1:0] nxt_psc;
  reg nxt_slot_clock;
  reg nxt_slot_loaded;

  // ---------------------------------------------------------------------
  // bus handshake state
  // ---------------------------------------------------------------------
  reg aw_held_ff;
  reg [ADDR_W-1:0] aw_addr_ff;
  reg w_held_ff;
  reg [31:0] w_data_ff;
  reg [3:0] w_strb_ff;
  reg bvalid_ff;
  reg [1:0] bresp_ff;
  reg rvalid_ff;
  reg [31:0] rdata_ff;
  reg [1:0] rresp_ff;

  wire aw_take;
  wire w_take;
  wire wr_fire;
  wire ar_take;
  wire [ADDR_W-1:0] wr_addr;
  wire [31:0] wr_data;
  wire [3:0] wr_strb;
  wire wr_hit_lcs;
  wire wr_hit_aux;
  wire [31:0] lcs_word;
  wire [31:0] aux_word;
  wire [2:0] l0s_exit_w;
  wire [2:0] l1_exit_w;
  wire lcs_wr_low;
  wire rd_hit_lcs;
  wire rd_hit_aux;
  reg [31:0] nxt_rdata;
  reg [1:0] nxt_rresp;

  // ---------------------------------------------------------------------
  // write channels
  // ---------------------------------------------------------------------
  // each channel is held once taken; a new one waits until the response
  // has gone, which keeps a single write in flight
  assign s_axi_awready = !aw_held_ff && !bvalid_ff;
  assign s_axi_wready = !w_held_ff && !bvalid_ff;
  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take = s_axi_wvalid && s_axi_wready;

  assign wr_addr = aw_held_ff ? aw_addr_ff : s_axi_awaddr;
  assign wr_data = w_held_ff ? w_data_ff : s_axi_wdata;
  assign wr_strb = w_held_ff ? w_strb_ff : s_axi_wstrb;
  assign wr_fire = (aw_held_ff || aw_take) && (w_held_ff || w_take);

  // byte lanes are dropped from the decode; each register is one word
  assign wr_hit_lcs = {wr_addr[ADDR_W-1:2], 2'b00} ==
                      `LCS_OFF_LINK_CTL_STAT;
  assign wr_hit_aux = {wr_addr[ADDR_W-1:2], 2'b00} ==
                      `LCS_OFF_LINK_AUX;

  // hold address and data until both halves have arrived
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      aw_held_ff <= 1'b0;
      aw_addr_ff <= {ADDR_W{1'b0}};
      w_held_ff <= 1'b0;
      w_data_ff <= 32'h0000_0000;
      w_strb_ff <= 4'h0;
    end else begin
      if (wr_fire) begin
        aw_held_ff <= 1'b0;
      end else if (aw_take) begin
        aw_held_ff <= 1'b1;
        aw_addr_ff <= s_axi_awaddr;
      end
      if (wr_fire) begin
        w_held_ff <= 1'b0;
      end else if (w_take) begin
        w_held_ff <= 1'b1;
        w_data_ff <= s_axi_wdata;
        w_strb_ff <= s_axi_wstrb;
      end
    end
  end

  // write response one cycle after both halves are in
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bvalid_ff <= 1'b0;
      bresp_ff <= `LCS_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_ff <= 1'b1;
      bresp_ff <= (wr_hit_lcs || wr_hit_aux) ? `LCS_RESP_OKAY :
                  `LCS_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_ff <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;

  // ---------------------------------------------------------------------
  // writable fields
  // ---------------------------------------------------------------------
  // only byte lane 0 carries writable bits; the other lanes hold fixed or
  // loaded values, so their strobes are ignored
  assign lcs_wr_low = wr_fire && wr_hit_lcs && wr_strb[0];

  // next values of the writable fields; they hold unless lane 0 is written
  always @* begin
    nxt_ext_sync = ext_sync_ff;
    nxt_common_clk = common_clk_ff;
    nxt_compl_bound = compl_bound_ff;
    nxt_psc = psc_ff;
    if (lcs_wr_low) begin
      nxt_ext_sync = wr_data[`LCS_BIT_EXT_SYNC];
      nxt_common_clk = wr_data[`LCS_BIT_COMMON_CLK];
      nxt_compl_bound = wr_data[`LCS_BIT_COMPL_BOUND];
      // unsupported codes fall back to disabled so no l1 entry is armed
      if (wr_data[`LCS_PSC_HI:`LCS_PSC_LO] == `LCS_PSC_L0S) begin
        nxt_psc = `LCS_PSC_L0S;
      end else begin
        nxt_psc = `LCS_PSC_DISABLED;
      end
    end
  end

  // writable fields reset to async clock, normal sync, no power entry
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ext_sync_ff <= 1'b0;
      common_clk_ff <= 1'b0;
      compl_bound_ff <= 1'b0;
      psc_ff <= `LCS_PSC_DISABLED;
    end else begin
      ext_sync_ff <= nxt_ext_sync;
      common_clk_ff <= nxt_common_clk;
      compl_bound_ff <= nxt_compl_bound;
      psc_ff <= nxt_psc;
    end
  end

  // ---------------------------------------------------------------------
  // slot clock flag
  // ---------------------------------------------------------------------
  // the loader is the only writer; software writes never touch it.
  // a second load is refused so late loader noise cannot flip it
  always @* begin
    nxt_slot_clock = slot_clock_ff;
    nxt_slot_loaded = slot_loaded_ff;
    if (slot_clock_load && !slot_loaded_ff) begin
      nxt_slot_clock = slot_clock_value;
      nxt_slot_loaded = 1'b1;
    end
  end

  // cleared only by reset, which is what lets a fresh load happen
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      slot_clock_ff <= 1'b0;
      slot_loaded_ff <= 1'b0;
    end else begin
      slot_clock_ff <= nxt_slot_clock;
      slot_loaded_ff <= nxt_slot_loaded;
    end
  end

  // ---------------------------------------------------------------------
  // synchronization length
  // ---------------------------------------------------------------------
  // registered so the link logic sees a clean level
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sync_len_ff <= `LCS_SYNC_NORMAL;
    end else begin
      sync_len_ff <= ext_sync_ff ? `LCS_SYNC_EXTENDED :
                     `LCS_SYNC_NORMAL;
    end
  end

  // ---------------------------------------------------------------------
  // exit latency selection
  // ---------------------------------------------------------------------
  // software sets both ends alike and retrains; this block only reports
  lcs_latency_sel i_lcs_latency_sel (
    .clk(clk),
    .arst_n(arst_n),
    .common_clock_select(common_clk_ff),
    .l0s_exit_ff(l0s_exit_w),
    .l1_exit_ff(l1_exit_w)
  );

  // ---------------------------------------------------------------------
  // read image
  // ---------------------------------------------------------------------
  // fixed and reserved positions are built from constants here, which is
  // why no write path can reach them
  assign lcs_word = {
    2'b00,
    1'b0,
    slot_clock_ff,
    2'b00,
    WIDTH_CODE,
    SPEED_CODE,
    8'h00,
    ext_sync_ff,
    common_clk_ff,
    1'b0,
    1'b0,
    compl_bound_ff,
    1'b0,
    psc_ff
  };

  // auxiliary status: exit latencies and loader state
  assign aux_word = {24'h00_0000, slot_loaded_ff, 1'b0, l1_exit_w,
                     l0s_exit_w};

  // ---------------------------------------------------------------------
  // read channel
  // ---------------------------------------------------------------------
  assign s_axi_arready = !rvalid_ff;
  assign ar_take = s_axi_arvalid && s_axi_arready;
  assign rd_hit_lcs = {s_axi_araddr[ADDR_W-1:2], 2'b00} ==
                      `LCS_OFF_LINK_CTL_STAT;
  assign rd_hit_aux = {s_axi_araddr[ADDR_W-1:2], 2'b00} ==
                      `LCS_OFF_LINK_AUX;

  // an unmapped read answers zero with an error, so a wrong offset never
  // returns stale data that looks valid
  always @* begin
    nxt_rdata = 32'h0000_0000;
    nxt_rresp = `LCS_RESP_SLVERR;
    if (rd_hit_lcs) begin
      nxt_rdata = lcs_word;
      nxt_rresp = `LCS_RESP_OKAY;
    end else if (rd_hit_aux) begin
      nxt_rdata = aux_word;
      nxt_rresp = `LCS_RESP_OKAY;
    end
  end

  // read data registered one cycle after the address is taken
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= `LCS_RESP_OKAY;
    end else if (ar_take) begin
      rvalid_ff <= 1'b1;
      rdata_ff <= nxt_rdata;
      rresp_ff <= nxt_rresp;
    end else if (s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

  // ---------------------------------------------------------------------
  // outputs to the link logic
  // ---------------------------------------------------------------------
  assign ext_sync_en = ext_sync_ff;
  assign sync_length = sync_len_ff;
  assign common_clock_select = common_clk_ff;
  assign completion_boundary_bit = compl_bound_ff;
  assign power_state_control_field = psc_ff;
  assign l0s_entry_en = psc_ff == `LCS_PSC_L0S;
  assign l0s_exit_latency = l0s_exit_w;
  assign l1_exit_latency = l1_exit_w;

endmodule
`default_nettype wire

/* lcs_defines.vh */
// lcs_defines.vh: offsets, field positions, reset values for the link
// control and status register block.
// assumes inclusion by bare name from the design files.
`ifndef LCS_DEFINES_VH
`define LCS_DEFINES_VH

// ---------------------------------------------------------------------
// register map
// ---------------------------------------------------------------------
`define LCS_ADDR_W 12
`define LCS_OFF_LINK_CTL_STAT 12'h0D0
`define LCS_OFF_LINK_AUX 12'h0D4
`define LCS_RESET_VALUE 32'h0011_0000

// ---------------------------------------------------------------------
// field positions inside link_control_status
// ---------------------------------------------------------------------
`define LCS_BIT_DATA_ACTIVE 29
`define LCS_BIT_SLOT_CLOCK 28
`define LCS_WIDTH_HI 25
`define LCS_WIDTH_LO 20
`define LCS_SPEED_HI 19
`define LCS_SPEED_LO 16
`define LCS_BIT_EXT_SYNC 7
`define LCS_BIT_COMMON_CLK 6
`define LCS_BIT_RETRAIN 5
`define LCS_BIT_LINK_OFF 4
`define LCS_BIT_COMPL_BOUND 3
`define LCS_BIT_RSVD2 2
`define LCS_PSC_HI 1
`define LCS_PSC_LO 0

// ---------------------------------------------------------------------
// fixed codes
// ---------------------------------------------------------------------
`define LCS_WIDTH_X1 6'h01
`define LCS_SPEED_2G5 4'h1
`define LCS_PSC_DISABLED 2'h0
`define LCS_PSC_L0S 2'h1

// ---------------------------------------------------------------------
// exit latency codes, asynchronous and common reference clock
// ---------------------------------------------------------------------
`define LCS_L0S_EXIT_ASYNC 3'h3
`define LCS_L0S_EXIT_COMMON 3'h3
`define LCS_L1_EXIT_ASYNC 3'h0
`define LCS_L1_EXIT_COMMON 3'h0

// ---------------------------------------------------------------------
// synchronization lengths in ordered sets
// ---------------------------------------------------------------------
`define LCS_SYNC_NORMAL 8'h01
`define LCS_SYNC_EXTENDED 8'h10

// ---------------------------------------------------------------------
// axi response codes
// ---------------------------------------------------------------------
`define LCS_RESP_OKAY 2'h0
`define LCS_RESP_SLVERR 2'h2

`endif

/* lcs_latency_sel.v */
// lcs_latency_sel.v: picks the exit latency codes that are reported,
// according to the current common clock selection.
// assumes the selection bit comes from a register on the same clock.
`include "lcs_defines.vh"
`default_nettype none

module lcs_latency_sel #(
  parameter [2:0] L0S_ASYNC = `LCS_L0S_EXIT_ASYNC,
  parameter [2:0] L0S_COMMON = `LCS_L0S_EXIT_COMMON,
  parameter [2:0] L1_ASYNC = `LCS_L1_EXIT_ASYNC,
  parameter [2:0] L1_COMMON = `LCS_L1_EXIT_COMMON
) (
  input wire clk,
  input wire arst_n,
  input wire common_clock_select,
  output reg [2:0] l0s_exit_ff,
  output reg [2:0] l1_exit_ff
);

  // ---------------------------------------------------------------------
  // latency registers
  // ---------------------------------------------------------------------
  wire [2:0] nxt_l0s_exit;
  wire [2:0] nxt_l1_exit;

  // the default codes are equal, so a shared reference clock leaves the exit time unchanged
  assign nxt_l0s_exit = common_clock_select ? L0S_COMMON : L0S_ASYNC;
  assign nxt_l1_exit = common_clock_select ? L1_COMMON : L1_ASYNC;

  // registered so the reported values change one cycle after the write
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      l0s_exit_ff <= `LCS_L0S_EXIT_ASYNC;
      l1_exit_ff <= `LCS_L1_EXIT_ASYNC;
    end else begin
      l0s_exit_ff <= nxt_l0s_exit;
      l1_exit_ff <= nxt_l1_exit;
    end
  end

endmodule
`default_nettype wire

/* lcs_link_ctl_stat_properties.sv */
// lcs_link_ctl_stat_properties.sv: assertions on the link control port.
// assumes a bind into lcs_link_ctl_stat, one clock, async low reset.
`include "lcs_defines.vh"
`default_nettype none
module lcs_link_ctl_stat_properties #(parameter ADDR_W = 12) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic ext_sync_en,
  input wire logic [7:0] sync_length,
  input wire logic common_clock_select,
  input wire logic completion_boundary_bit,
  input wire logic [1:0] power_state_control_field,
  input wire logic l0s_entry_en,
  input wire logic [2:0] l0s_exit_latency,
  input wire logic [2:0] l1_exit_latency
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // read or write of the control word taken at this edge
  wire rd_ctl = s_axi_arvalid && s_axi_arready && s_axi_araddr == 'h0D0;
  wire wr_ctl = s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready && s_axi_awaddr == 'h0D0 && s_axi_wstrb[0];
  a_hardwired_zero: assert property (
    rd_ctl |=> s_axi_rvalid && s_axi_rdata[31:29] == 3'h0 &&
    s_axi_rdata[27:26] == 2'h0 && s_axi_rdata[15:8] == 8'h00 &&
    s_axi_rdata[5:4] == 2'h0 && s_axi_rdata[2] == 1'b0)
    else $error("fixed zero bits set");
  a_width_speed: assert property (
    rd_ctl |=> s_axi_rdata[25:16] == 10'h011)
    else $error("width or speed code wrong");
  a_ctl_readback: assert property (
    rd_ctl |=> s_axi_rdata[7] == ext_sync_en &&
    s_axi_rdata[6] == common_clock_select &&
    s_axi_rdata[3] == completion_boundary_bit &&
    s_axi_rdata[1:0] == power_state_control_field)
    else $error("readback differs from controls");
  a_write_lands: assert property (wr_ctl |=>
    ext_sync_en == $past(s_axi_wdata[7]) && common_clock_select ==
    $past(s_axi_wdata[6]) && completion_boundary_bit == $past(s_axi_wdata[3]))
    else $error("written control bit lost");
  a_psc_legal: assert property (wr_ctl |=> power_state_control_field ==
    ($past(s_axi_wdata[1:0]) == 2'h1 ? 2'h1 : 2'h0))
    else $error("power state code stored wrongly");
  a_l0s_entry: assert property (l0s_entry_en ==
    (power_state_control_field == 2'h1)) else $error("l0s entry mismatch");
  a_sync_long: assert property (ext_sync_en ##1 ext_sync_en |->
    sync_length == 8'h10) else $error("sync not extended");
  a_sync_short: assert property (!ext_sync_en ##1 !ext_sync_en |->
    sync_length == 8'h01) else $error("sync not normal");
  a_exit_latency: assert property (l0s_exit_latency ==
    ($past(common_clock_select) ? `LCS_L0S_EXIT_COMMON : `LCS_L0S_EXIT_ASYNC)
    && l1_exit_latency == ($past(common_clock_select) ?
    `LCS_L1_EXIT_COMMON : `LCS_L1_EXIT_ASYNC))
    else $error("exit latency code wrong");
endmodule
bind lcs_link_ctl_stat lcs_link_ctl_stat_properties #(.ADDR_W(ADDR_W))
  i_props (.*);
`default_nettype wire

/* lcs_axi_master.sv */
// lcs_axi_master.sv: configuration software as an axi4-lite master.
// assumes one clock and one call at a time; hung flags a lost answer.
`default_nettype none
module lcs_axi_master (
  input wire logic clk,
  output logic [11:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  output logic [11:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready,
  output logic hung
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, hung} = 4'h0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 26'h0;
    {s_axi_wdata, s_axi_wstrb} = 36'h0;
  end
  // software programs the control bits; ready sampled mid-cycle, so the
  // value seen is the one the slave holds at the next rising edge
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
      input logic [3:0] s, output logic [1:0] r);
    logic pa, pw, pb, ta, tw, tb;
    int n;
    {pa, pw, pb, r} = 5'h1F;
    @(posedge clk);
    {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, s};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    for (n = 0; n < 40 && (pa || pw || pb); n++) begin
      @(negedge clk);
      {ta, tw, tb} = {pa & s_axi_awready, pw & s_axi_wready,
                      pb & s_axi_bvalid};
      if (tb) r = s_axi_bresp;
      @(posedge clk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tb) s_axi_bready <= 1'b0;
      {pa, pw, pb} = {pa & !ta, pw & !tw, pb & !tb};
    end
    if (pa || pw || pb) hung <= 1'b1;
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d,
      output logic [1:0] r);
    logic pa, pb, ta, tb;
    int n;
    {pa, pb, r, d} = 36'hF_FFFF_FFFF;
    @(posedge clk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    for (n = 0; n < 40 && (pa || pb); n++) begin
      @(negedge clk);
      {ta, tb} = {pa & s_axi_arready, pb & s_axi_rvalid};
      if (tb) {d, r} = {s_axi_rdata, s_axi_rresp};
      @(posedge clk);
      if (ta) s_axi_arvalid <= 1'b0;
      if (tb) s_axi_rready <= 1'b0;
      {pa, pb} = {pa & !ta, pb & !tb};
    end
    if (pa || pb) hung <= 1'b1;
  endtask
endmodule
`default_nettype wire

/* lcs_link_ctl_stat_tb.sv */
// lcs_link_ctl_stat_tb.sv: self-checking bench for the link control word.
// assumes the master model and the bound property checker.
`default_nettype none
module lcs_link_ctl_stat_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [2:0] s_axi_awprot = 3'h0;
  logic [2:0] s_axi_arprot = 3'h0;
  logic slot_clock_load = 1'b0;
  logic slot_clock_value = 1'b0;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, hung;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, ext_sync_en, common_clock_select;
  logic completion_boundary_bit, l0s_entry_en;
  logic [31:0] s_axi_wdata, s_axi_rdata, m, d, q;
  logic [3:0] s_axi_wstrb, s;
  logic [1:0] s_axi_bresp, s_axi_rresp, power_state_control_field, r;
  logic [7:0] sync_length;
  logic [2:0] l0s_exit_latency, l1_exit_latency;
  int n_mismatch = 0;
  int total_checks = 0;
  int seed = 17420;
  int i;
  wire [19:0] pins = {ext_sync_en, common_clock_select,
    completion_boundary_bit, l0s_entry_en, power_state_control_field,
    sync_length, l0s_exit_latency, l1_exit_latency};
  lcs_link_ctl_stat i_lcs_link_ctl_stat (.*);
  lcs_axi_master i_lcs_axi_master (.*);
  always #5 clk = ~clk;
  always @(posedge hung) begin
    n_mismatch++;
    final_report;
  end
  // ------------------------------------------------------------------
  // expectations
  // ------------------------------------------------------------------
  // only the low byte moves; psc codes 10 and 11 store 00
  function automatic logic [31:0] nxt_reg(logic [31:0] o, logic [31:0] w,
      logic [3:0] b);
    nxt_reg = o;
    if (b[0]) nxt_reg[7:0] = {w[7:6], 2'h0, w[3], 2'h0, w[1:0] == 2'h1};
  endfunction
  function automatic logic [19:0] exp_pins(logic [31:0] v);
    exp_pins = {v[7:6], v[3], v[1:0] == 2'h1, v[1:0],
      v[7] ? 8'h10 : 8'h01, 3'h3, 3'h0};
  endfunction
  // ------------------------------------------------------------------
  // compares and bus steps
  // ------------------------------------------------------------------
  task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %0t word %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk_resp(input logic [1:0] g, input logic [1:0] e);
    total_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %0t resp %h expected %h", $time, g, e);
    end
  endtask
  task automatic wrchk(input logic [11:0] a, input logic [31:0] w,
      input logic [3:0] b, input logic [1:0] er);
    i_lcs_axi_master.wr(a, w, b, r);
    if (a == 12'h0D0) m = nxt_reg(m, w, b);
    chk_resp(r, er);
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] e,
      input logic [1:0] er);
    i_lcs_axi_master.rd(a, q, r);
    chk_word(q, e);
    chk_resp(r, er);
  endtask
  task automatic pulse(input logic v);
    @(posedge clk);
    {slot_clock_load, slot_clock_value} <= {1'b1, v};
    @(posedge clk);
    {slot_clock_load, slot_clock_value} <= {1'b0, !v};
  endtask
  task automatic reset_dut;
    @(posedge clk);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    m = 32'h0011_0000;
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial begin
    reset_dut;
    rdchk(12'h0D0, m, 2'h0);
    wrchk(12'h0D0, 32'hFFFF_FFFF, 4'hF, 2'h0);
    rdchk(12'h0D0, m, 2'h0);
    // first four passes walk every power state code
    for (i = 0; i < 24; i++) begin
      d = $random(seed);
      s = 4'($random(seed));
      // early passes force lane 0 so every power code reaches the field
      if (i < 4) {d[1:0], s[0]} = {i[1:0], 1'b1};
      wrchk(12'h0D0, d, s, 2'h0);
      rdchk(12'h0D0, m, 2'h0);
      repeat (2) @(posedge clk);
      chk_word({12'h0, pins}, {12'h0, exp_pins(m)});
    end
    wrchk(12'h0D4, 32'hFFFF_FFFF, 4'hF, 2'h0);
    rdchk(12'h0D4, 32'h0000_0003, 2'h0);
    wrchk(12'h0D8, 32'h0, 4'hF, 2'h2);
    rdchk(12'h0D8, 32'h0, 2'h2);
    rdchk(12'h0D0, m, 2'h0);
    // slot clock loads once; software cannot clear it
    pulse(1'b1);
    m[28] = 1'b1;
    rdchk(12'h0D0, m, 2'h0);
    rdchk(12'h0D4, 32'h0000_0083, 2'h0);
    pulse(1'b0);
    wrchk(12'h0D0, 32'h0, 4'hF, 2'h0);
    rdchk(12'h0D0, m, 2'h0);
    reset_dut;
    rdchk(12'h0D0, m, 2'h0);
    final_report;
  end
endmodule
`default_nettype wire
